/* hdl/timer16_control_capture_compare.sv */
// 16-bit timer with prescaler, input capture and forced compare channels
`timescale 1ns/10ps
`default_nettype none

// How it works
// - With filter on, filtered capture input changes after four equal samples.
// - Filter on delays every capture event by exactly four clock cycles.
// - Edge select zero captures on falling edge, one on rising edge.
// - Capture copies counter into capture register and sets capture flag.
// - Modes using capture register as top disable capturing entirely.
// - Clock select codes: stop, undivided, divide by 8, 64, 256, 1024.
// - Code 110 counts external falling edges, code 111 rising edges.
// - External pin counts even when driven as an output by software.
// - Force bits act only in non-PWM modes, ignored in PWM modes.
// - Force bit write is a strobe applying compare output mode immediately.
// - Forced compare sets no flag and never clears the counter.
// - Force bits always read back as zero.
// - Shared high-byte latch makes 16-bit reads and writes atomic.
// - Counter write blocks compare matches on the next timer clock.
// - Non-PWM compare modes: disconnect, toggle, clear, set on match.
// - Mode bits from control B and A select top; every mode counts up and wraps to zero.
module timer16_control_capture_compare
    import timer16_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic [7:0]          regAddr,
    input  wire logic                regWrEn,
    input  wire logic [7:0]          regWrData,
    input  wire logic                regRdEn,
    output var  logic [7:0]          regRdData,
    input  wire logic                captureInputPin,
    input  wire logic                externalCountPin,
    input  wire logic                captureFlagClear,
    output var  logic                captureFlag,
    output var  logic [CHANNELS-1:0] compareOutputPin,
    output var  logic [CHANNELS-1:0] compareOutputEnable
);

    typedef struct packed {
        logic [7:0]          ctrlA;
        logic [7:0]          ctrlB;
        logic [15:0]         count;
        logic [15:0]         cmpA;
        logic [15:0]         cmpB;
        logic [15:0]         cmpC;
        logic [15:0]         capReg;
        logic [7:0]          temp;
        logic                capFlag;
        logic [CHANNELS-1:0] pinOut;
        logic [CHANNELS-1:0] pinEn;
        logic [9:0]          prescale;
        logic                capSync1;
        logic                capSync2;
        logic [2:0]          capHist;
        logic                capFilt;
        logic                capPrev;
        logic                extSync1;
        logic                extSync2;
        logic                extPrev;
        logic                blockMatch;
        logic [7:0]          rdData;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // Top value for the selected waveform mode
    function automatic logic [15:0] topValue(input logic [3:0] wgm,
                                             input logic [15:0] cmpA,
                                             input logic [15:0] capReg);
        case (wgm)
            WGM_PC8, WGM_FAST8:                                 topValue = TOP_8BIT;
            WGM_PC9, WGM_FAST9:                                 topValue = TOP_9BIT;
            WGM_PC10, WGM_FAST10:                               topValue = TOP_10BIT;
            WGM_PFC_CAP, WGM_PC_CAP, WGM_CTC_CAP, WGM_FAST_CAP: topValue = capReg;
            WGM_NORMAL, WGM_RESERVED:                           topValue = TOP_MAX;
            default:                                            topValue = cmpA;
        endcase
    endfunction : topValue

    // True when the capture register serves as top
    function automatic logic capIsTop(input logic [3:0] wgm);
        capIsTop = (wgm == WGM_PFC_CAP) || (wgm == WGM_PC_CAP) ||
                   (wgm == WGM_CTC_CAP) || (wgm == WGM_FAST_CAP);
    endfunction : capIsTop

    // True for the non-PWM modes
    function automatic logic nonPwm(input logic [3:0] wgm);
        nonPwm = (wgm == WGM_NORMAL) || (wgm == WGM_CTC_A) || (wgm == WGM_CTC_CAP);
    endfunction : nonPwm

    // Timer clock enable from the clock source select field
    function automatic logic timerTick(input logic [2:0] cs,
                                       input logic [9:0] pre,
                                       input logic       extRise,
                                       input logic       extFall);
        case (cs)
            CS_DIV1:     timerTick = 1'b1;
            CS_DIV8:     timerTick = ((pre & PRE_MASK8) == PRE_MASK8);
            CS_DIV64:    timerTick = ((pre & PRE_MASK64) == PRE_MASK64);
            CS_DIV256:   timerTick = ((pre & PRE_MASK256) == PRE_MASK256);
            CS_DIV1024:  timerTick = ((pre & PRE_MASK1024) == PRE_MASK1024);
            CS_EXT_FALL: timerTick = extFall;
            CS_EXT_RISE: timerTick = extRise;
            default:     timerTick = 1'b0;
        endcase
    endfunction : timerTick

    // New compare output level for a match
    function automatic logic comAction(input logic [1:0] com, input logic pin);
        case (com)
            COM_TOGGLE: comAction = ~pin;
            COM_CLEAR:  comAction = 1'b0;
            COM_SET:    comAction = 1'b1;
            default:    comAction = pin;
        endcase
    endfunction : comAction

    logic [3:0]          wgm;
    logic [15:0]         top;
    logic                tick;
    logic                capIn;
    logic                capTrig;
    logic [3:0]          histAll;
    logic [CHANNELS-1:0] match;
    logic [CHANNELS-1:0] forceHit;
    logic [15:0]         cmpVal [CHANNELS];

    assign cmpVal[0] = st_r.cmpA;
    assign cmpVal[1] = st_r.cmpB;
    assign cmpVal[2] = st_r.cmpC;

    always_comb begin
        st_nxt = st_r;
        wgm = {st_r.ctrlB[WGM_HI_MSB -: 2], st_r.ctrlA[WGM_LO_MSB -: 2]};
        top = topValue(wgm, st_r.cmpA, st_r.capReg);

        // Pin synchronisers
        st_nxt.capSync1 = captureInputPin;
        st_nxt.capSync2 = st_r.capSync1;
        st_nxt.extSync1 = externalCountPin;
        st_nxt.extSync2 = st_r.extSync1;
        st_nxt.extPrev  = st_r.extSync2;

        // four equal samples move the filter
        st_nxt.capHist = {st_r.capHist[1:0], st_r.capSync2};
        histAll = {st_r.capHist, st_r.capSync2};
        if ((&histAll) || !(|histAll)) begin
            st_nxt.capFilt = st_r.capSync2;
        end
        capIn = st_r.ctrlB[NOISE_BIT] ? st_r.capFilt : st_r.capSync2;
        st_nxt.capPrev = capIn;
        capTrig = st_r.ctrlB[EDGE_BIT] ? (capIn & ~st_r.capPrev) : (~capIn & st_r.capPrev);
        // capture off when capture register is top
        capTrig = capTrig & ~capIsTop(wgm);

        st_nxt.prescale = st_r.prescale + 10'h001;
        tick = timerTick(st_r.ctrlB[CS_MSB -: 3], st_r.prescale,
                         st_r.extSync2 & ~st_r.extPrev, ~st_r.extSync2 & st_r.extPrev);

        if (tick) begin
            st_nxt.count      = (st_r.count == top) ? 16'h0000 : st_r.count + 16'h0001;
            st_nxt.blockMatch = 1'b0;
        end

        forceHit = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            match[i] = tick && !st_r.blockMatch && (st_r.count == cmpVal[i]);
        end

        st_nxt.capFlag = capTrig | (st_r.capFlag & ~captureFlagClear);
        if (capTrig) begin
            st_nxt.capReg = st_r.count;
        end

        // low byte read loads the shared latch
        st_nxt.rdData = 8'h00;
        if (regRdEn) begin
            case (regAddr)
                ADDR_CNT_LO: begin
                    st_nxt.rdData = st_r.count[7:0];
                    st_nxt.temp   = st_r.count[15:8];
                end
                ADDR_CAP_LO: begin
                    st_nxt.rdData = st_r.capReg[7:0];
                    st_nxt.temp   = st_r.capReg[15:8];
                end
                ADDR_CMP_A_LO: begin
                    st_nxt.rdData = st_r.cmpA[7:0];
                    st_nxt.temp   = st_r.cmpA[15:8];
                end
                ADDR_CMP_B_LO: begin
                    st_nxt.rdData = st_r.cmpB[7:0];
                    st_nxt.temp   = st_r.cmpB[15:8];
                end
                ADDR_CMP_C_LO: begin
                    st_nxt.rdData = st_r.cmpC[7:0];
                    st_nxt.temp   = st_r.cmpC[15:8];
                end
                ADDR_CNT_HI, ADDR_CAP_HI, ADDR_CMP_A_HI, ADDR_CMP_B_HI, ADDR_CMP_C_HI: begin
                    st_nxt.rdData = st_r.temp;
                end
                ADDR_CTRL_A: st_nxt.rdData = st_r.ctrlA;
                ADDR_CTRL_B: st_nxt.rdData = st_r.ctrlB & CTRL_B_WMASK;
                ADDR_CTRL_C: st_nxt.rdData = 8'h00;
                default:     st_nxt.rdData = 8'h00;
            endcase
        end

        if (regWrEn) begin
            case (regAddr)
                ADDR_CNT_HI, ADDR_CAP_HI, ADDR_CMP_A_HI, ADDR_CMP_B_HI, ADDR_CMP_C_HI: begin
                    st_nxt.temp = regWrData;
                end
                // low byte write commits both bytes
                ADDR_CNT_LO: begin
                    st_nxt.count      = {st_r.temp, regWrData};
                    st_nxt.blockMatch = 1'b1;
                end
                ADDR_CAP_LO:   st_nxt.capReg = {st_r.temp, regWrData};
                ADDR_CMP_A_LO: st_nxt.cmpA   = {st_r.temp, regWrData};
                ADDR_CMP_B_LO: st_nxt.cmpB   = {st_r.temp, regWrData};
                ADDR_CMP_C_LO: st_nxt.cmpC   = {st_r.temp, regWrData};
                ADDR_CTRL_A:   st_nxt.ctrlA  = regWrData;
                ADDR_CTRL_B:   st_nxt.ctrlB  = regWrData & CTRL_B_WMASK;
                ADDR_CTRL_C: begin
                    for (int i = 0; i < CHANNELS; i++) begin
                        forceHit[i] = regWrData[FORCE_A_BIT - i] & nonPwm(wgm);
                    end
                end
                default: begin
                end
            endcase
        end

        for (int i = 0; i < CHANNELS; i++) begin
            if (nonPwm(wgm) && match[i]) begin
                st_nxt.pinOut[i] = comAction(st_r.ctrlA[COM_A_MSB - 2*i -: 2], st_r.pinOut[i]);
            end
            // forced strobe uses current output mode
            // no flag and no counter clear here
            if (forceHit[i]) begin
                st_nxt.pinOut[i] = comAction(st_r.ctrlA[COM_A_MSB - 2*i -: 2], st_r.pinOut[i]);
            end
            st_nxt.pinEn[i] = (st_nxt.ctrlA[COM_A_MSB - 2*i -: 2] != COM_OFF);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData           = st_r.rdData;
    assign captureFlag         = st_r.capFlag;
    assign compareOutputPin    = st_r.pinOut;
    assign compareOutputEnable = st_r.pinEn;

endmodule : timer16_control_capture_compare

`default_nettype wire

/* hdl/timer16_pkg.sv */
// Constants for the 16-bit timer with capture and compare channels
package timer16_pkg;
    // Byte addresses of the register locations
    localparam logic [7:0] ADDR_CMP_B_LO  = 8'h48;
    localparam logic [7:0] ADDR_CMP_B_HI  = 8'h49;
    localparam logic [7:0] ADDR_CMP_A_LO  = 8'h4A;
    localparam logic [7:0] ADDR_CMP_A_HI  = 8'h4B;
    localparam logic [7:0] ADDR_CMP_C_LO  = 8'h78;
    localparam logic [7:0] ADDR_CMP_C_HI  = 8'h79;
    localparam logic [7:0] ADDR_CTRL_C    = 8'h8C;
    localparam logic [7:0] ADDR_CNT_LO    = 8'h4C;
    localparam logic [7:0] ADDR_CNT_HI    = 8'h4D;
    localparam logic [7:0] ADDR_CTRL_B    = 8'h4E;
    localparam logic [7:0] ADDR_CTRL_A    = 8'h4F;
    localparam logic [7:0] ADDR_CAP_LO    = 8'h46;
    localparam logic [7:0] ADDR_CAP_HI    = 8'h47;

    // Field positions in control register B
    localparam int         NOISE_BIT      = 7;
    localparam int         EDGE_BIT       = 6;
    localparam int         WGM_HI_MSB     = 4;
    localparam int         CS_MSB         = 2;
    localparam logic [7:0] CTRL_B_WMASK   = 8'hDF;
    // Field positions in control register A and C
    localparam int         COM_A_MSB      = 7;
    localparam int         WGM_LO_MSB     = 1;
    localparam int         FORCE_A_BIT    = 7;

    // Clock source select codes
    localparam logic [2:0] CS_STOP        = 3'h0;
    localparam logic [2:0] CS_DIV1        = 3'h1;
    localparam logic [2:0] CS_DIV8        = 3'h2;
    localparam logic [2:0] CS_DIV64       = 3'h3;
    localparam logic [2:0] CS_DIV256      = 3'h4;
    localparam logic [2:0] CS_DIV1024     = 3'h5;
    localparam logic [2:0] CS_EXT_FALL    = 3'h6;
    localparam logic [2:0] CS_EXT_RISE    = 3'h7;

    // Prescaler terminal masks
    localparam logic [9:0] PRE_MASK8      = 10'h007;
    localparam logic [9:0] PRE_MASK64     = 10'h03F;
    localparam logic [9:0] PRE_MASK256    = 10'h0FF;
    localparam logic [9:0] PRE_MASK1024   = 10'h3FF;

    // Waveform mode codes used in decoding
    localparam logic [3:0] WGM_NORMAL     = 4'h0;
    localparam logic [3:0] WGM_PC8        = 4'h1;
    localparam logic [3:0] WGM_PC9        = 4'h2;
    localparam logic [3:0] WGM_PC10       = 4'h3;
    localparam logic [3:0] WGM_CTC_A      = 4'h4;
    localparam logic [3:0] WGM_FAST8      = 4'h5;
    localparam logic [3:0] WGM_FAST9      = 4'h6;
    localparam logic [3:0] WGM_FAST10     = 4'h7;
    localparam logic [3:0] WGM_PFC_CAP    = 4'h8;
    localparam logic [3:0] WGM_PC_CAP     = 4'hA;
    localparam logic [3:0] WGM_CTC_CAP    = 4'hC;
    localparam logic [3:0] WGM_RESERVED   = 4'hD;
    localparam logic [3:0] WGM_FAST_CAP   = 4'hE;

    // Fixed top values
    localparam logic [15:0] TOP_MAX       = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT      = 16'h00FF;
    localparam logic [15:0] TOP_9BIT      = 16'h01FF;
    localparam logic [15:0] TOP_10BIT     = 16'h03FF;

    // Compare output modes
    localparam logic [1:0] COM_OFF        = 2'h0;
    localparam logic [1:0] COM_TOGGLE     = 2'h1;
    localparam logic [1:0] COM_CLEAR      = 2'h2;
    localparam logic [1:0] COM_SET        = 2'h3;

    localparam int         CHANNELS       = 3;
endpackage : timer16_pkg

/* tb/timer16_chk.sv */
// Port checker for the 16-bit timer block
`timescale 1ns/10ps
`default_nettype none
module timer16_chk
    import timer16_pkg::*;
(
    input wire logic                mclk,
    input wire logic                reset,
    input wire logic [7:0]          regAddr,
    input wire logic                regWrEn,
    input wire logic [7:0]          regWrData,
    input wire logic                regRdEn,
    input wire logic [7:0]          regRdData,
    input wire logic                captureInputPin,
    input wire logic                captureFlagClear,
    input wire logic                captureFlag,
    input wire logic [CHANNELS-1:0] compareOutputPin,
    input wire logic [CHANNELS-1:0] compareOutputEnable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_rd(a);
        regRdEn && regAddr == a;
    endsequence
    sequence s_wr_a;
        regWrEn && regAddr == ADDR_CTRL_A;
    endsequence
    chk_rd_idle_zero: assert property (!regRdEn |=> regRdData == 8'h00)
        else $error("read data not zero while idle");
    chk_force_reads_zero: assert property (s_rd(ADDR_CTRL_C) |=> regRdData == 8'h00)
        else $error("control C read not zero");
    chk_resv_bit_zero: assert property (s_rd(ADDR_CTRL_B) |=> !regRdData[5])
        else $error("control B bit 5 read as one");
    chk_flag_sticky: assert property (captureFlag && !captureFlagClear |=> captureFlag)
        else $error("capture flag dropped without clear");
    chk_flag_cause: assert property ($rose(captureFlag) |->
        $past(captureInputPin, 3) != $past(captureInputPin, 4) ||
        $past(captureInputPin, 7) != $past(captureInputPin, 8))
        else $error("capture flag without pin edge");
    chk_enable_cause: assert property ($changed(compareOutputEnable) |->
        $past(regWrEn && regAddr == ADDR_CTRL_A) || $past(reset))
        else $error("output enable changed without write");
    chk_enable_value: assert property (s_wr_a |=> compareOutputEnable ==
        {|$past(regWrData[3:2]), |$past(regWrData[5:4]), |$past(regWrData[7:6])})
        else $error("output enable wrong after control A write");
    chk_reset_outputs: assert property (disable iff (1'b0) reset |=>
        regRdData == 8'h00 && !captureFlag && compareOutputPin == 3'h0 &&
        compareOutputEnable == 3'h0)
        else $error("outputs not cleared by reset");
endmodule : timer16_chk
`default_nettype wire

/* tb/timer16_control_capture_compare_tb.sv */
// Self-checking bench for the 16-bit timer block
`timescale 1ns/10ps
`default_nettype none
module timer16_control_capture_compare_tb
    import timer16_pkg::*;
;
    localparam int         DIVS [6] = '{1, 1, 8, 64, 256, 1024};
    localparam logic [7:0] FA [4]   = '{8'hD8, 8'hD8, 8'hB4, 8'hB5};
    localparam logic [2:0] FP [4]   = '{3'h3, 3'h1, 3'h6, 3'h6};
    localparam logic [7:0] HIS [3]  = '{ADDR_CMP_A_HI, ADDR_CMP_B_HI, ADDR_CMP_C_HI};
    localparam logic [7:0] ALL [14] = '{ADDR_CMP_B_LO, ADDR_CMP_B_HI, ADDR_CMP_A_LO,
        ADDR_CMP_A_HI, ADDR_CMP_C_LO, ADDR_CMP_C_HI, ADDR_CTRL_C, ADDR_CNT_LO, ADDR_CNT_HI,
        ADDR_CTRL_B, ADDR_CTRL_A, ADDR_CAP_LO, ADDR_CAP_HI, 8'h00};
    logic        mclk = 1'b0, reset = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
    logic        captureInputPin = 1'b1, externalCountPin = 1'b0, captureFlagClear = 1'b0;
    logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic        captureFlag, rdSeen = 1'b0;
    logic [2:0]  compareOutputPin, compareOutputEnable;
    logic [7:0]  expQ [$];
    logic [15:0] v16, cnt;
    int          failCount = 0, nChecks = 0, k;
    timer16_control_capture_compare i_dut (.mclk, .reset, .regAddr, .regWrEn, .regWrData,
        .regRdEn, .regRdData, .captureInputPin, .externalCountPin, .captureFlagClear,
        .captureFlag, .compareOutputPin, .compareOutputEnable);
    always #5 mclk = ~mclk;
    task automatic check(input bit ok, input string msg);
        nChecks++;
        if (!ok) begin
            failCount++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task automatic finalReport;
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finalReport
    always @(posedge mclk) begin
        if (rdSeen && expQ.size() > 0) begin
            check(regRdData === expQ.pop_front(), "read data");
        end
        rdSeen <= regRdEn;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge mclk);
        regWrEn   <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input bit q);
        @(posedge mclk);
        regAddr <= a;
        regRdEn <= 1'b1;
        if (q) expQ.push_back(e);
        @(posedge mclk);
        regRdEn <= 1'b0;
        @(negedge mclk);
    endtask : rd
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a - 8'h01, v[7:0]);
    endtask : wr16
    task automatic rd16(input logic [7:0] a, input logic [15:0] e, input bit q);
        rd(a, e[7:0], q);
        v16[7:0] = regRdData;
        rd(a + 8'h01, e[15:8], q);
        v16[15:8] = regRdData;
    endtask : rd16
    task automatic clr;
        @(posedge mclk);
        captureFlagClear <= 1'b1;
        @(posedge mclk);
        captureFlagClear <= 1'b0;
        @(negedge mclk);
    endtask : clr
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : idle
    initial begin
        void'($urandom(42));
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        foreach (ALL[i]) rd(ALL[i], 8'h00, 1'b1);
        $display("reset values done");
        for (int i = 0; i < 3; i++) begin
            cnt = 16'($urandom());
            wr16(HIS[i], cnt);
            rd16(HIS[i] - 8'h01, cnt, 1'b1);
        end
        wr(ADDR_CTRL_B, 8'hE0);
        rd(ADDR_CTRL_B, 8'hC0, 1'b1);
        wr(ADDR_CTRL_C, 8'hE0);
        rd(ADDR_CTRL_C, 8'h00, 1'b1);
        $display("register access done");
        for (int c = 0; c < 6; c++) begin
            wr16(ADDR_CNT_HI, 16'h0000);
            wr(ADDR_CTRL_B, 8'(c));
            repeat (20 * DIVS[c]) @(posedge mclk);
            wr(ADDR_CTRL_B, 8'h00);
            rd16(ADDR_CNT_LO, 16'h0000, 1'b0);
            check(c == 0 ? v16 === 16'h0000 : v16 >= 16'h0013 && v16 <= 16'h0017, "rate");
        end
        for (int c = 6; c < 8; c++) begin
            wr16(ADDR_CNT_HI, 16'h0000);
            wr(ADDR_CTRL_B, 8'(c));
            repeat (10) begin
                repeat (4) @(posedge mclk);
                externalCountPin <= ~externalCountPin;
            end
            idle(6);
            wr(ADDR_CTRL_B, 8'h00);
            rd16(ADDR_CNT_LO, 16'h0005, 1'b1);
        end
        $display("clock select done");
        cnt = 16'($urandom());
        wr16(ADDR_CNT_HI, cnt);
        for (int e = 0; e < 2; e++) begin
            for (int f = 0; f < 2; f++) begin
                wr(ADDR_CTRL_B, 8'(f * 128 + e * 64));
                captureInputPin <= e[0];
                idle(12);
                clr();
                captureInputPin <= ~e[0];
                idle(12);
                check(captureFlag === 1'b0, "wrong edge");
                if (f == 1) begin
                    captureInputPin <= e[0];
                    repeat (3) @(posedge mclk);
                    captureInputPin <= ~e[0];
                    idle(12);
                    check(captureFlag === 1'b0, "glitch");
                end
                @(posedge mclk);
                captureInputPin <= e[0];
                for (k = 1; k <= 20 && captureFlag !== 1'b1; k++) idle(1);
                check(k - 1 == (f == 1 ? 7 : 3), "latency");
                if (k > 20) finalReport();
                rd16(ADDR_CAP_LO, cnt, 1'b1);
                clr();
                check(captureFlag === 1'b0, "flag clear");
            end
        end
        wr(ADDR_CTRL_B, 8'h18);
        captureInputPin <= 1'b0;
        idle(12);
        check(captureFlag === 1'b0, "top mode capture");
        wr(ADDR_CTRL_B, 8'h00);
        $display("capture done");
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL_A, FA[i]);
            wr(ADDR_CTRL_C, 8'hE0);
            idle(2);
            check(compareOutputPin === FP[i] && compareOutputEnable === 3'h7, "force");
        end
        check(captureFlag === 1'b0, "force flag");
        rd16(ADDR_CNT_LO, cnt, 1'b1);
        $display("force compare done");
        wr(ADDR_CTRL_A, 8'h40);
        wr16(ADDR_CMP_A_HI, 16'h0005);
        wr16(ADDR_CNT_HI, 16'h0100);
        wr(ADDR_CTRL_B, 8'(CS_DIV1));
        wr16(ADDR_CNT_HI, 16'h0005);
        idle(20);
        check(compareOutputPin[0] === 1'b0, "blocked match");
        wr16(ADDR_CNT_HI, 16'h0004);
        idle(20);
        check(compareOutputPin[0] === 1'b1, "next match");
        wr(ADDR_CTRL_B, 8'h00);
        $display("counter write done");
        finalReport();
    end
endmodule : timer16_control_capture_compare_tb
bind timer16_control_capture_compare timer16_chk i_chk (.mclk, .reset, .regAddr, .regWrEn,
    .regWrData, .regRdEn, .regRdData, .captureInputPin, .captureFlagClear, .captureFlag,
    .compareOutputPin, .compareOutputEnable);
`default_nettype wire
